// file: inc/dcds_pkg.sv
// constants and types for the clock, delay loop and sysref config bank
// assumes byte-wide registers on a 15-bit serial-port address space
package dcds_pkg;
	// --------------------------------------------------------------------
	// serial port framing
	// --------------------------------------------------------------------
	localparam int ADDR_W = 15;
	localparam int RNW_BIT = 15;
	typedef logic [ADDR_W-1:0] dcds_addr_t;
	typedef logic [7:0]        dcds_byte_t;
	typedef logic [4:0]        dcds_cnt_t;
	localparam dcds_cnt_t INSTR_LAST = 5'h0f;
	localparam dcds_cnt_t DATA_FIRST = 5'h10;
	localparam dcds_cnt_t DATA_LAST  = 5'h17;
	// --------------------------------------------------------------------
	// register offsets, writable masks, reset values
	// --------------------------------------------------------------------
	localparam dcds_addr_t OFS_REF_CLK    = 15'h084;
	localparam dcds_addr_t OFS_SYSREF_CFG = 15'h088;
	localparam dcds_addr_t OFS_SYSREF_HYS = 15'h089;
	localparam dcds_addr_t OFS_DLL_PWR    = 15'h090;
	localparam dcds_addr_t OFS_DLL_POL    = 15'h091;
	localparam dcds_byte_t MASK_REF_CLK    = 8'h31;
	localparam dcds_byte_t MASK_SYSREF_CFG = 8'h0f;
	localparam dcds_byte_t MASK_SYSREF_HYS = 8'hff;
	localparam dcds_byte_t MASK_DLL_PWR    = 8'h1f;
	localparam dcds_byte_t MASK_DLL_POL    = 8'he0;
	localparam dcds_byte_t RST_REF_CLK    = 8'h00;
	localparam dcds_byte_t RST_SYSREF_CFG = 8'h00;
	localparam dcds_byte_t RST_SYSREF_HYS = 8'h00;
	localparam dcds_byte_t RST_DLL_PWR    = 8'h1f;
	localparam dcds_byte_t RST_DLL_POL    = 8'he0;
	// --------------------------------------------------------------------
	// field positions
	// --------------------------------------------------------------------
	localparam int REF_RATE_LSB   = 4;
	localparam int REF_PD_BIT     = 0;
	localparam int SYSREF_HYSTERESIS_ENABLE_BIT     = 3;
	localparam int EDGE_BIT       = 2;
	localparam int HYS_HI_LSB     = 0;
	localparam int FINE_DC_BIT    = 4;
	localparam int FINE_XC_BIT    = 3;
	localparam int COARSE_DC_BIT  = 2;
	localparam int COARSE_XC_BIT  = 1;
	localparam int DELAY_LOOP_POWER_AND_CORRECTION_BIT     = 0;
	localparam int TRACK_ERR_BIT  = 7;
	localparam int SEARCH_ERR_BIT = 6;
	localparam int SLOPE_BIT      = 5;
	// --------------------------------------------------------------------
	// field codes
	// --------------------------------------------------------------------
	typedef enum logic [1:0] {
		RATE_X1  = 2'h0,
		RATE_X2  = 2'h1,
		RATE_X4  = 2'h2,
		RATE_OFF = 2'h3
	} dcds_rate_e;
	typedef logic [2:0] dcds_mult_t;
	localparam dcds_mult_t MULT_X1   = 3'h1;
	localparam dcds_mult_t MULT_X2   = 3'h2;
	localparam dcds_mult_t MULT_X4   = 3'h4;
	localparam dcds_mult_t MULT_NONE = 3'h0;
	localparam int HYS_W = 10;
	typedef logic [6:0] dcds_mv_t;
	localparam dcds_mv_t HYS_STEP_MV = 7'h0a;
endpackage

// file: inc/dcds_ctrl_if.sv
// register access strobes between the serial engine and the bank
// assumes one clock; rdata answers combinationally to addr
`timescale 1ns/100ps
`default_nettype none
interface dcds_ctrl_if;
	import dcds_pkg::*;
	dcds_addr_t addr;
	logic       wr_stb;
	dcds_byte_t wdata;
	dcds_byte_t rdata;
	modport spi (output addr, output wr_stb, output wdata, input rdata);
	modport regs (input addr, input wr_stb, input wdata, output rdata);
endinterface
`default_nettype wire

// file: hw/dcds_sync.sv
// two-stage synchroniser for pin inputs
// assumes inputs are asynchronous to clk and change slowly
`timescale 1ns/100ps
`default_nettype none
module dcds_sync #(
	parameter int          W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire logic [W-1:0] async_in,
	output var  logic [W-1:0] sync_out
);
	logic [W-1:0] meta_ff;
	// first stage feeds only the second
	always_ff @(posedge clk) begin
		if (!rstn) begin
			meta_ff  <= RST_VAL;
			sync_out <= RST_VAL;
		end else begin
			meta_ff  <= async_in;
			sync_out <= meta_ff;
		end
	end
endmodule // dcds_sync
`default_nettype wire

// file: hw/dcds_spi_slave.sv
// serial control port engine: 16-bit instruction then data bytes
// assumes synchronised pins and sclk slower than clk by at least 8x
`timescale 1ns/100ps
`default_nettype none
module dcds_spi_slave
	import dcds_pkg::*;
(
	input  wire logic  clk,
	input  wire logic  rstn,
	input  wire logic  cs_n_s,
	input  wire logic  sclk_s,
	input  wire logic  sdi_s,
	output var  logic  sdo,
	output var  logic  sdo_oe_n,
	dcds_ctrl_if.spi   bus
);
	logic        sclk_d_ff;
	dcds_cnt_t   cnt_ff;
	logic [15:0] instr_ff;
	dcds_byte_t  rx_ff;
	dcds_byte_t  tx_ff;
	logic        rnw_ff;
	logic        load_ff;
	logic        adv_ff;
	dcds_addr_t  addr_ff;
	logic        wr_stb_ff;
	dcds_byte_t  wdata_ff;
	logic        active;
	logic        rise;
	logic        fall;
	logic        instr_done;
	logic        byte_done;
	logic [15:0] nxt_instr;
	dcds_byte_t  nxt_rx;

	assign active     = ~cs_n_s;
	assign rise       = active & sclk_s & ~sclk_d_ff;
	assign fall       = active & ~sclk_s & sclk_d_ff;
	assign nxt_instr  = {instr_ff[14:0], sdi_s};
	assign nxt_rx     = {rx_ff[6:0], sdi_s};
	assign instr_done = rise & (cnt_ff == INSTR_LAST);
	assign byte_done  = rise & (cnt_ff == DATA_LAST);
	assign bus.addr   = addr_ff;
	assign bus.wr_stb = wr_stb_ff;
	assign bus.wdata  = wdata_ff;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			sclk_d_ff <= 1'b0;
		end else begin
			sclk_d_ff <= sclk_s;
		end
	end

	// bytes stream until chip select rises
	always_ff @(posedge clk) begin
		if (!rstn || !active) begin
			cnt_ff   <= '0;
			instr_ff <= '0;
			rx_ff    <= '0;
		end else if (rise) begin
			if (cnt_ff <= INSTR_LAST) begin
				instr_ff <= nxt_instr;
			end else begin
				rx_ff <= nxt_rx;
			end
			cnt_ff <= (cnt_ff == DATA_LAST) ? DATA_FIRST : dcds_cnt_t'(cnt_ff + 5'h01);
		end
	end

	// address ascends after each byte
	always_ff @(posedge clk) begin
		if (!rstn) begin
			addr_ff <= '0;
			rnw_ff  <= 1'b0;
		end else if (instr_done) begin
			addr_ff <= nxt_instr[ADDR_W-1:0];
			rnw_ff  <= nxt_instr[RNW_BIT];
		end else if (adv_ff) begin
			addr_ff <= dcds_addr_t'(addr_ff + 15'h0001);
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			wr_stb_ff <= 1'b0;
			wdata_ff  <= '0;
			adv_ff    <= 1'b0;
			load_ff   <= 1'b0;
		end else begin
			wr_stb_ff <= byte_done & ~rnw_ff;
			adv_ff    <= byte_done;
			load_ff   <= instr_done | adv_ff;
			if (byte_done) begin
				wdata_ff <= nxt_rx;
			end
		end
	end

	// read data leaves on falling sclk, msb first
	always_ff @(posedge clk) begin
		if (!rstn) begin
			tx_ff    <= '0;
			sdo      <= 1'b0;
			sdo_oe_n <= 1'b1;
		end else if (!active) begin
			sdo_oe_n <= 1'b1;
		end else if (load_ff) begin
			tx_ff <= bus.rdata;
		end else if (fall && rnw_ff && cnt_ff >= DATA_FIRST) begin
			sdo      <= tx_ff[7];
			tx_ff    <= {tx_ff[6:0], 1'b0};
			sdo_oe_n <= 1'b0;
		end
	end
endmodule // dcds_spi_slave
`default_nettype wire

// file: hw/dcds_top.sv
// config bank for reference clock, sysref receiver and delay loop
// assumes serial pins are asynchronous; dll controller events are on clk
`timescale 1ns/100ps
`default_nettype none
module dcds_top
	import dcds_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               rstn,
	input  wire logic               spi_cs_n,
	input  wire logic               spi_sclk,
	input  wire logic               spi_sdi,
	output var  logic               spi_sdo,
	output var  logic               spi_sdo_oe_n,
	input  wire logic               dll_search_error,
	input  wire logic               dll_track_error,
	output var  dcds_pkg::dcds_rate_e ref_clk_rate,
	output var  logic               ref_clock_power_down,
	output var  logic               ref_clk_active,
	output var  dcds_pkg::dcds_mult_t ref_clk_mult,
	output var  logic               sysref_hysteresis_enable,
	output var  logic               sysref_edge_select,
	output var  logic [9:0]         sysref_hysteresis_amount,
	output var  logic [9:0]         sysref_hysteresis_applied,
	output var  dcds_pkg::dcds_mv_t sysref_hysteresis_mv,
	output var  logic               fine_line_duty_correct_en,
	output var  logic               fine_line_cross_control_en,
	output var  logic               coarse_line_duty_correct_en,
	output var  logic               coarse_line_cross_control_en,
	output var  logic               delay_loop_power_down,
	output var  logic               clock_gen_power_down,
	output var  logic               dll_ctrl_power_up,
	output var  logic               dll_slope,
	output var  logic               dll_search_err_retry,
	output var  logic               dll_track_err_restart,
	output var  logic               dll_search_halt,
	output var  logic               dll_search_retry,
	output var  logic               dll_track_restart
);
	import dcds_pkg::*;

	// --------------------------------------------------------------------
	// functions
	// --------------------------------------------------------------------
	function automatic logic hit(dcds_addr_t a, dcds_addr_t ofs);
		hit = (a == ofs);
	endfunction

	function automatic dcds_mult_t rate_mult(logic [1:0] code);
		unique case (code)
			RATE_X1: rate_mult = MULT_X1;
			RATE_X2: rate_mult = MULT_X2;
			RATE_X4: rate_mult = MULT_X4;
			RATE_OFF: rate_mult = MULT_NONE;
		endcase
	endfunction

	// each set bit adds one 10 mV step, so the sum is ten times the population count
	function automatic dcds_mv_t hys_mv(logic [HYS_W-1:0] v);
		dcds_mv_t acc;
		acc = '0;
		for (int i = 0; i < HYS_W; i++) begin
			if (v[i]) begin
				acc = dcds_mv_t'(acc + HYS_STEP_MV);
			end
		end
		hys_mv = acc;
	endfunction

	// --------------------------------------------------------------------
	// pins and serial engine
	// --------------------------------------------------------------------
	logic cs_n_s;
	logic sclk_s;
	logic sdi_s;

	dcds_ctrl_if bus ();

	dcds_sync #(
		.W       (3),
		.RST_VAL (3'h4)
	) u_sync (
		.clk      (clk),
		.rstn     (rstn),
		.async_in ({spi_cs_n, spi_sclk, spi_sdi}),
		.sync_out ({cs_n_s, sclk_s, sdi_s})
	);

	dcds_spi_slave u_spi (
		.clk      (clk),
		.rstn     (rstn),
		.cs_n_s   (cs_n_s),
		.sclk_s   (sclk_s),
		.sdi_s    (sdi_s),
		.sdo      (spi_sdo),
		.sdo_oe_n (spi_sdo_oe_n),
		.bus      (bus)
	);

	// --------------------------------------------------------------------
	// register storage
	// --------------------------------------------------------------------
	dcds_byte_t ref_clk_ff;
	dcds_byte_t sysref_cfg_ff;
	dcds_byte_t sysref_hys_ff;
	dcds_byte_t dll_pwr_ff;
	dcds_byte_t dll_pol_ff;
	logic       wr_ref;
	logic       wr_cfg;
	logic       wr_hys;
	logic       wr_pwr;
	logic       wr_pol;

	assign wr_ref = bus.wr_stb & hit(bus.addr, OFS_REF_CLK);
	assign wr_cfg = bus.wr_stb & hit(bus.addr, OFS_SYSREF_CFG);
	assign wr_hys = bus.wr_stb & hit(bus.addr, OFS_SYSREF_HYS);
	assign wr_pwr = bus.wr_stb & hit(bus.addr, OFS_DLL_PWR);
	assign wr_pol = bus.wr_stb & hit(bus.addr, OFS_DLL_POL);

	// masking keeps reserved bits at zero
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ref_clk_ff <= RST_REF_CLK;
		end else if (wr_ref) begin
			ref_clk_ff <= bus.wdata & MASK_REF_CLK;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			sysref_cfg_ff <= RST_SYSREF_CFG;
		end else if (wr_cfg) begin
			sysref_cfg_ff <= bus.wdata & MASK_SYSREF_CFG;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			sysref_hys_ff <= RST_SYSREF_HYS;
		end else if (wr_hys) begin
			sysref_hys_ff <= bus.wdata & MASK_SYSREF_HYS;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			dll_pwr_ff <= RST_DLL_PWR;
		end else if (wr_pwr) begin
			dll_pwr_ff <= bus.wdata & MASK_DLL_PWR;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			dll_pol_ff <= RST_DLL_POL;
		end else if (wr_pol) begin
			dll_pol_ff <= bus.wdata & MASK_DLL_POL;
		end
	end

	// --------------------------------------------------------------------
	// read back
	// --------------------------------------------------------------------
	// unmapped addresses read zero
	always_comb begin
		bus.rdata = '0;
		if (hit(bus.addr, OFS_REF_CLK)) begin
			bus.rdata = ref_clk_ff;
		end else if (hit(bus.addr, OFS_SYSREF_CFG)) begin
			bus.rdata = sysref_cfg_ff;
		end else if (hit(bus.addr, OFS_SYSREF_HYS)) begin
			bus.rdata = sysref_hys_ff;
		end else if (hit(bus.addr, OFS_DLL_PWR)) begin
			bus.rdata = dll_pwr_ff;
		end else if (hit(bus.addr, OFS_DLL_POL)) begin
			bus.rdata = dll_pol_ff;
		end
	end

	// --------------------------------------------------------------------
	// direct field outputs
	// --------------------------------------------------------------------
	assign ref_clk_rate                 = dcds_rate_e'(ref_clk_ff[REF_RATE_LSB +: 2]);
	assign ref_clock_power_down         = ref_clk_ff[REF_PD_BIT];
	assign sysref_hysteresis_enable     = sysref_cfg_ff[SYSREF_HYSTERESIS_ENABLE_BIT];
	assign sysref_edge_select           = sysref_cfg_ff[EDGE_BIT];
	assign sysref_hysteresis_amount     = {sysref_cfg_ff[HYS_HI_LSB +: 2], sysref_hys_ff};
	assign fine_line_duty_correct_en    = dll_pwr_ff[FINE_DC_BIT];
	assign fine_line_cross_control_en   = dll_pwr_ff[FINE_XC_BIT];
	assign coarse_line_duty_correct_en  = dll_pwr_ff[COARSE_DC_BIT];
	assign coarse_line_cross_control_en = dll_pwr_ff[COARSE_XC_BIT];
	assign delay_loop_power_down        = dll_pwr_ff[DELAY_LOOP_POWER_AND_CORRECTION_BIT];
	assign dll_slope                    = dll_pol_ff[SLOPE_BIT];
	assign dll_search_err_retry         = dll_pol_ff[SEARCH_ERR_BIT];
	assign dll_track_err_restart        = dll_pol_ff[TRACK_ERR_BIT];

	// --------------------------------------------------------------------
	// decoded outputs
	// --------------------------------------------------------------------
	// one cycle behind the register, so outputs stay flop-driven
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ref_clk_mult <= MULT_NONE;
		end else begin
			ref_clk_mult <= ref_clk_ff[REF_PD_BIT] ? MULT_NONE
			                : rate_mult(ref_clk_ff[REF_RATE_LSB +: 2]);
		end
	end

	// power down overrides any rate code
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ref_clk_active <= 1'b0;
		end else begin
			ref_clk_active <= ~ref_clk_ff[REF_PD_BIT]
			                  & (ref_clk_ff[REF_RATE_LSB +: 2] != RATE_OFF);
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			sysref_hysteresis_applied <= '0;
		end else if (sysref_cfg_ff[SYSREF_HYSTERESIS_ENABLE_BIT]) begin
			sysref_hysteresis_applied <= {sysref_cfg_ff[HYS_HI_LSB +: 2], sysref_hys_ff};
		end else begin
			sysref_hysteresis_applied <= '0;
		end
	end

	// same gate as applied, so both outputs move on one edge
	always_ff @(posedge clk) begin
		if (!rstn) begin
			sysref_hysteresis_mv <= '0;
		end else if (sysref_cfg_ff[SYSREF_HYSTERESIS_ENABLE_BIT]) begin
			sysref_hysteresis_mv <= hys_mv({sysref_cfg_ff[HYS_HI_LSB +: 2], sysref_hys_ff});
		end else begin
			sysref_hysteresis_mv <= '0;
		end
	end

	// the clock generator shares the loop's power bit
	always_ff @(posedge clk) begin
		if (!rstn) begin
			clock_gen_power_down <= RST_DLL_PWR[DELAY_LOOP_POWER_AND_CORRECTION_BIT];
		end else begin
			clock_gen_power_down <= dll_pwr_ff[DELAY_LOOP_POWER_AND_CORRECTION_BIT];
		end
	end

	// controller power is the inverse sense of the same bit
	always_ff @(posedge clk) begin
		if (!rstn) begin
			dll_ctrl_power_up <= ~RST_DLL_PWR[DELAY_LOOP_POWER_AND_CORRECTION_BIT];
		end else begin
			dll_ctrl_power_up <= ~dll_pwr_ff[DELAY_LOOP_POWER_AND_CORRECTION_BIT];
		end
	end

	// --------------------------------------------------------------------
	// controller error policy
	// --------------------------------------------------------------------
	// errors from a powered-down controller are ignored
	logic ctrl_on;
	assign ctrl_on = ~dll_pwr_ff[DELAY_LOOP_POWER_AND_CORRECTION_BIT];

	always_ff @(posedge clk) begin
		if (!rstn) begin
			dll_search_retry <= 1'b0;
		end else begin
			dll_search_retry <= ctrl_on & dll_search_error & dll_pol_ff[SEARCH_ERR_BIT];
		end
	end

	// continue on track error means no pulse at all
	always_ff @(posedge clk) begin
		if (!rstn) begin
			dll_track_restart <= 1'b0;
		end else begin
			dll_track_restart <= ctrl_on & dll_track_error & dll_pol_ff[TRACK_ERR_BIT];
		end
	end

	// halt holds until software rewrites policy or powers down;
	// a new error in the policy-write clearing cycle keeps the halt
	always_ff @(posedge clk) begin
		if (!rstn) begin
			dll_search_halt <= 1'b0;
		end else if (ctrl_on && dll_search_error && !dll_pol_ff[SEARCH_ERR_BIT]) begin
			dll_search_halt <= 1'b1;
		end else if (wr_pol || !ctrl_on) begin
			dll_search_halt <= 1'b0;
		end
	end
endmodule // dcds_top
`default_nettype wire

// file: tb/dcds_top_asserts.sv
// assertions on the decoded outputs of the config bank
// assumes binding into dcds_top, one clock, rstn synchronous active low
`timescale 1ns/100ps
`default_nettype none
module dcds_top_asserts
	import dcds_pkg::*;
(
	input wire logic                 clk,
	input wire logic                 rstn,
	input wire logic                 dll_search_error,
	input wire logic                 dll_track_error,
	input wire dcds_pkg::dcds_rate_e ref_clk_rate,
	input wire logic                 ref_clock_power_down,
	input wire logic                 ref_clk_active,
	input wire dcds_pkg::dcds_mult_t ref_clk_mult,
	input wire logic                 sysref_hysteresis_enable,
	input wire logic [9:0]           sysref_hysteresis_amount,
	input wire logic [9:0]           sysref_hysteresis_applied,
	input wire dcds_pkg::dcds_mv_t   sysref_hysteresis_mv,
	input wire logic                 delay_loop_power_down,
	input wire logic                 clock_gen_power_down,
	input wire logic                 dll_ctrl_power_up,
	input wire logic                 dll_search_err_retry,
	input wire logic                 dll_track_err_restart,
	input wire logic                 dll_search_halt,
	input wire logic                 dll_search_retry,
	input wire logic                 dll_track_restart
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// ----------------------------------------------------------------
	// clock and sysref fields
	// ----------------------------------------------------------------
	pd_mult_a: assert property (ref_clock_power_down |=> ref_clk_mult == MULT_NONE && !ref_clk_active)
		else $error("multiplier not cleared by power down");
	rate_x4_a: assert property (!ref_clock_power_down && ref_clk_rate == RATE_X4 |=> ref_clk_mult == MULT_X4)
		else $error("quad rate not decoded");
	hys_gate_a: assert property (!sysref_hysteresis_enable |=> sysref_hysteresis_applied == 10'h000)
		else $error("hysteresis applied while disabled");
	hys_pass_a: assert property (sysref_hysteresis_enable |=> sysref_hysteresis_applied == $past(sysref_hysteresis_amount))
		else $error("applied hysteresis differs from amount");
	// settled value only: the mv flop moves on the same edge as applied
	hys_mv_a: assert property ($stable(sysref_hysteresis_applied) [*2] |-> sysref_hysteresis_mv == 7'($countones(sysref_hysteresis_applied) * 10))
		else $error("hysteresis millivolts wrong");
	// ----------------------------------------------------------------
	// delay loop power and error policy
	// ----------------------------------------------------------------
	pwr_pair_a: assert property ($fell(delay_loop_power_down) |=> !clock_gen_power_down && dll_ctrl_power_up)
		else $error("loop and generator not powered up together");
	retry_on_a: assert property (dll_search_error && !delay_loop_power_down && dll_search_err_retry |=> dll_search_retry)
		else $error("search retry missing");
	stop_on_a: assert property (dll_search_error && !delay_loop_power_down && !dll_search_err_retry |=> dll_search_halt && !dll_search_retry)
		else $error("search stop missing");
	restart_on_a: assert property (dll_track_error && !delay_loop_power_down && dll_track_err_restart |=> dll_track_restart)
		else $error("track restart missing");
	pd_ignore_a: assert property (delay_loop_power_down |=> !dll_search_retry && !dll_track_restart)
		else $error("error acted on while powered down");
endmodule // dcds_top_asserts
bind dcds_top dcds_top_asserts u_asserts (.clk, .rstn, .dll_search_error, .dll_track_error, .ref_clk_rate,
	.ref_clock_power_down, .ref_clk_active, .ref_clk_mult, .sysref_hysteresis_enable, .sysref_hysteresis_amount,
	.sysref_hysteresis_applied, .sysref_hysteresis_mv, .delay_loop_power_down, .clock_gen_power_down,
	.dll_ctrl_power_up, .dll_search_err_retry, .dll_track_err_restart, .dll_search_halt, .dll_search_retry,
	.dll_track_restart);
`default_nettype wire

// file: tb/dcds_top_bench.sv
// self-checking bench for the clock, delay loop and sysref config bank
// assumes dcds_top reached only through its serial port, mode 0
`timescale 1ns/100ps
`default_nettype none
module dcds_top_bench;
	import dcds_pkg::*;
	logic       clk, rstn, spi_cs_n, spi_sclk, spi_sdi, spi_sdo, spi_sdo_oe_n;
	logic       dll_search_error, dll_track_error, ref_clock_power_down, ref_clk_active;
	dcds_rate_e ref_clk_rate;
	dcds_mult_t ref_clk_mult;
	dcds_mv_t   sysref_hysteresis_mv;
	logic [9:0] sysref_hysteresis_amount, sysref_hysteresis_applied;
	logic       sysref_hysteresis_enable, sysref_edge_select, fine_line_duty_correct_en;
	logic       fine_line_cross_control_en, coarse_line_duty_correct_en, coarse_line_cross_control_en;
	logic       delay_loop_power_down, clock_gen_power_down, dll_ctrl_power_up, dll_slope;
	logic       dll_search_err_retry, dll_track_err_restart, dll_search_halt, dll_search_retry, dll_track_restart;
	int         errors, tests_run;
	logic       oe_rd;
	dcds_addr_t ofs [5] = '{OFS_REF_CLK, OFS_SYSREF_CFG, OFS_SYSREF_HYS, OFS_DLL_PWR, OFS_DLL_POL};
	dcds_byte_t rsv [5] = '{RST_REF_CLK, RST_SYSREF_CFG, RST_SYSREF_HYS, RST_DLL_PWR, RST_DLL_POL};
	dcds_byte_t msk [5] = '{MASK_REF_CLK, MASK_SYSREF_CFG, MASK_SYSREF_HYS, MASK_DLL_PWR, MASK_DLL_POL};
	dcds_mult_t mult [4] = '{MULT_X1, MULT_X2, MULT_X4, MULT_NONE};
	dcds_top uut (.clk, .rstn, .spi_cs_n, .spi_sclk, .spi_sdi, .spi_sdo, .spi_sdo_oe_n, .dll_search_error,
		.dll_track_error, .ref_clk_rate, .ref_clock_power_down, .ref_clk_active, .ref_clk_mult,
		.sysref_hysteresis_enable, .sysref_edge_select, .sysref_hysteresis_amount, .sysref_hysteresis_applied,
		.sysref_hysteresis_mv, .fine_line_duty_correct_en, .fine_line_cross_control_en,
		.coarse_line_duty_correct_en, .coarse_line_cross_control_en, .delay_loop_power_down,
		.clock_gen_power_down, .dll_ctrl_power_up, .dll_slope, .dll_search_err_retry, .dll_track_err_restart,
		.dll_search_halt, .dll_search_retry, .dll_track_restart);
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk_reg(input string n, input dcds_byte_t e, input dcds_byte_t g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_out(input string n, input logic [9:0] e, input logic [9:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	// ten clk per sclk half keeps well clear of the synchroniser limit
	task automatic xfer(input logic rnw, input dcds_addr_t a, input dcds_byte_t wd, output dcds_byte_t rd);
		logic [23:0] f;
		f = {rnw, a, wd};
		rd = 8'h00;
		spi_cs_n <= 1'b0;
		repeat (10) @(posedge clk);
		for (int i = 23; i >= 0; i--) begin
			spi_sdi <= f[i];
			repeat (10) @(posedge clk);
			if (i < 8)
				rd[i] = spi_sdo;
			if (i == 0)
				oe_rd = spi_sdo_oe_n;
			spi_sclk <= 1'b1;
			repeat (10) @(posedge clk);
			spi_sclk <= 1'b0;
		end
		repeat (10) @(posedge clk);
		spi_cs_n <= 1'b1;
		repeat (10) @(posedge clk);
	endtask
	task automatic wr(input dcds_addr_t a, input dcds_byte_t d);
		dcds_byte_t r;
		xfer(1'b0, a, d, r);
	endtask
	task automatic rd_chk(input dcds_addr_t a, input dcds_byte_t e);
		dcds_byte_t r;
		xfer(1'b1, a, 8'h00, r);
		chk_reg($sformatf("reg %h", a), e, r);
		chk_reg("sdo enable", 8'h00, {7'h00, oe_rd});
	endtask
	// two cycles of {halt, retry, restart} after a one-cycle error pulse
	task automatic err_pulse(input logic trk, output logic [5:0] s);
		if (trk)
			dll_track_error <= 1'b1;
		else
			dll_search_error <= 1'b1;
		@(posedge clk);
		dll_track_error <= 1'b0;
		dll_search_error <= 1'b0;
		#1 s[5:3] = {dll_search_halt, dll_search_retry, dll_track_restart};
		@(posedge clk);
		#1 s[2:0] = {dll_search_halt, dll_search_retry, dll_track_restart};
		@(posedge clk);
	endtask
	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		repeat (60000) @(posedge clk);
		errors++;
		give_verdict();
	end
	initial begin
		logic [5:0] s;
		rstn = 1'b0;
		spi_cs_n = 1'b1;
		spi_sclk = 1'b0;
		spi_sdi = 1'b0;
		dll_search_error = 1'b0;
		dll_track_error = 1'b0;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		for (int i = 0; i < 5; i++)
			rd_chk(ofs[i], rsv[i]);
		rd_chk(15'h085, 8'h00);
		chk_out("mult", MULT_X1, ref_clk_mult);
		chk_out("dll bits", 10'h07e, {fine_line_duty_correct_en, fine_line_cross_control_en, coarse_line_duty_correct_en, coarse_line_cross_control_en, delay_loop_power_down, clock_gen_power_down, dll_ctrl_power_up});
		for (int i = 0; i < 5; i++) begin
			wr(ofs[i], 8'hff);
			rd_chk(ofs[i], msk[i]);
		end
		wr(15'h085, 8'hff);
		rd_chk(15'h085, 8'h00);
		chk_out("amount", 10'h3ff, sysref_hysteresis_amount);
		chk_out("mv", 10'h064, sysref_hysteresis_mv);
		err_pulse(1'b0, s);
		chk_out("ignored", 10'h000, s);
		wr(OFS_SYSREF_CFG, 8'h02);
		chk_out("edge applied mv", 10'h000, {sysref_edge_select, sysref_hysteresis_applied[8:0]} | sysref_hysteresis_mv);
		wr(OFS_SYSREF_HYS, 8'ha5);
		wr(OFS_SYSREF_CFG, 8'h0e);
		chk_out("enable edge", 10'h003, {sysref_hysteresis_enable, sysref_edge_select});
		chk_out("applied", 10'h2a5, sysref_hysteresis_applied);
		chk_out("mv", 10'h032, sysref_hysteresis_mv);
		for (int r = 0; r < 4; r++) begin
			wr(OFS_REF_CLK, {r[1:0], 4'h0});
			chk_out("rate", r[1:0], ref_clk_rate);
			chk_out("mult act", {mult[r], r != 3}, {ref_clk_mult, ref_clk_active});
		end
		wr(OFS_REF_CLK, 8'h01);
		chk_out("pd mult act", 10'h010, {ref_clock_power_down, ref_clk_mult, ref_clk_active});
		wr(OFS_DLL_PWR, 8'h00);
		chk_out("dll bits", 10'h001, {fine_line_duty_correct_en, fine_line_cross_control_en, coarse_line_duty_correct_en, coarse_line_cross_control_en, delay_loop_power_down, clock_gen_power_down, dll_ctrl_power_up});
		err_pulse(1'b0, s);
		chk_out("search retry", 10'h010, s);
		err_pulse(1'b1, s);
		chk_out("track restart", 10'h008, s);
		wr(OFS_DLL_POL, 8'h20);
		chk_out("policy bits", 10'h001, {dll_track_err_restart, dll_search_err_retry, dll_slope});
		err_pulse(1'b0, s);
		chk_out("search stop", 10'h024, s);
		err_pulse(1'b1, s);
		chk_out("track continue", 10'h024, s);
		wr(OFS_DLL_POL, 8'he0);
		chk_out("halt cleared", 10'h000, dll_search_halt);
		chk_out("policy bits", 10'h007, {dll_track_err_restart, dll_search_err_retry, dll_slope});
		give_verdict();
	end
endmodule // dcds_top_bench
`default_nettype wire
